// *** include/burst_sram_pkg.sv ***
// Shared constants and carriers of the pipelined burst SRAM access logic
package burst_sram_pkg;
   // ==========================================================================
   // Geometry
   localparam int ADDR_W = 18;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int DATA_W = LANES * LANE_W;
   localparam int BURST_W = 2;
   localparam int DEPTH = 1 << ADDR_W;

   // ==========================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SLEEP_ENTRY_NS = 16;
   localparam int SLEEP_EXIT_NS = 16;
   // Longest entry rounds down, least recovery rounds up, never below one cycle
   localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (SLEEP_ENTRY_NS / CLK_PERIOD_NS);
   localparam int SLEEP_EXIT_CYC = ((SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
      1 : ((SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] SLEEP_ENTRY_CNT = 2'(SLEEP_ENTRY_CYC - 1);
   localparam logic [1:0] SLEEP_EXIT_CNT = 2'(SLEEP_EXIT_CYC - 1);

   // ==========================================================================
   // Reset values and encodings
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [LANES-1:0] LANES_OFF = 4'hF;
   localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;
   localparam logic [2:0] SYNC_IDLE_LOW = 3'h0;

   typedef enum logic [1:0] {AWAKE, ENTERING, ASLEEP, LEAVING} power_state_t;

   // One pipeline stage of an accepted access
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lane_sel_n;
   } access_t;

   localparam access_t ACCESS_IDLE = '{valid: 1'b0, write: 1'b0, addr: '0,
      lane_sel_n: LANES_OFF};
endpackage

// *** hw/burst_sram_core.sv ***
// Synchronous access pipeline, burst counter and sleep control of a burst SRAM
`timescale 1ns/100ps
module burst_sram_core
   import burst_sram_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clk_qualify_n,
   input wire logic chip_select_1_n,
   input wire logic chip_select_2,
   input wire logic chip_select_3_n,
   input wire logic write_enable_n,
   input wire logic advance_or_load,
   input wire logic [LANES-1:0] byte_lane_select_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic burst_order,
   input wire logic out_drive_enable_n,
   input wire logic sleep_request,
   input wire logic [DATA_W-1:0] data_lines_in,
   output logic [DATA_W-1:0] data_lines_out,
   output logic data_lines_oe,
   input wire logic [LANES-1:0] parity_lines_in,
   output logic [LANES-1:0] parity_lines_out,
   output logic parity_lines_oe
);
   // ==========================================================================
   // Pin synchronisers for the asynchronous inputs
   logic [2:0] oe_sync;
   logic [2:0] sleep_sync;
   logic [2:0] order_sync;
   logic oe_level_n;
   logic sleep_level;
   logic order_level;

   // Three stages each; a level counts once stages two and three agree
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         oe_sync <= SYNC_IDLE_HIGH;
         sleep_sync <= SYNC_IDLE_LOW;
         order_sync <= SYNC_IDLE_HIGH;
      end else begin
         oe_sync <= {oe_sync[1:0], out_drive_enable_n};
         sleep_sync <= {sleep_sync[1:0], sleep_request};
         order_sync <= {order_sync[1:0], burst_order};
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         oe_level_n <= 1'b1;
         sleep_level <= 1'b0;
         order_level <= 1'b1;
      end else begin
         if (oe_sync[1] == oe_sync[2]) oe_level_n <= oe_sync[2];
         if (sleep_sync[1] == sleep_sync[2]) sleep_level <= sleep_sync[2];
         if (order_sync[1] == order_sync[2]) order_level <= order_sync[2];
      end
   end

   // ==========================================================================
   // Sleep control
   power_state_t power_state;
   logic [1:0] power_cnt;
   logic qual;
   logic awake;

   assign qual = !clk_qualify_n;
   assign awake = (power_state == AWAKE);

   // Entry and exit run on plain time, not on qualified edges, so a stalled
   // controller still sees the required two-cycle windows
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         power_state <= AWAKE;
         power_cnt <= 2'h0;
      end else begin
         case (power_state)
            AWAKE: begin
               if (sleep_level) begin
                  power_state <= ENTERING;
                  power_cnt <= SLEEP_ENTRY_CNT;
               end
            end
            ENTERING: begin
               if (power_cnt == 2'h0) power_state <= ASLEEP;
               else power_cnt <= power_cnt - 2'h1;
            end
            ASLEEP: begin
               if (!sleep_level) begin
                  power_state <= LEAVING;
                  power_cnt <= SLEEP_EXIT_CNT;
               end
            end
            LEAVING: begin
               if (power_cnt == 2'h0) power_state <= AWAKE;
               else power_cnt <= power_cnt - 2'h1;
            end
            default: power_state <= AWAKE;
         endcase
      end
   end

   // ==========================================================================
   // Command decode and burst address
   logic all_selected;
   logic [BURST_W-1:0] burst_start;
   logic [BURST_W-1:0] burst_step;
   logic [BURST_W-1:0] next_step;
   logic [BURST_W-1:0] next_low;
   access_t stage_cmd;
   access_t stage_wr;
   access_t next_cmd;

   assign all_selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
   assign next_step = burst_step + BURST_STEP;
   // Both orders only touch the two lowest bits and wrap by width
   assign next_low = order_level ? (burst_start ^ next_step)
      : (burst_start + next_step);

   always_comb begin
      next_cmd = stage_cmd;
      if (advance_or_load) begin
         // Continue whatever the burst was, including a deselect
         next_cmd.addr = {stage_cmd.addr[ADDR_W-1:BURST_W], next_low};
         next_cmd.lane_sel_n = byte_lane_select_n;
      end else begin
         next_cmd.valid = all_selected;
         next_cmd.write = !write_enable_n;
         next_cmd.addr = address;
         next_cmd.lane_sel_n = byte_lane_select_n;
      end
   end

   // Input register stage; sleep throws away anything pending
   always_ff @(posedge mclk) begin
      if (!resetn || !awake) begin
         stage_cmd <= ACCESS_IDLE;
         burst_start <= 2'h0;
         burst_step <= 2'h0;
      end else if (qual) begin
         stage_cmd <= next_cmd;
         if (advance_or_load) begin
            burst_step <= next_step;
         end else begin
            burst_start <= address[BURST_W-1:0];
            burst_step <= 2'h0;
         end
      end
   end

   // Write data phase: one edge later the controller owns the bus
   always_ff @(posedge mclk) begin
      if (!resetn || !awake) begin
         stage_wr <= ACCESS_IDLE;
      end else if (qual) begin
         stage_wr <= stage_cmd;
         stage_wr.valid <= stage_cmd.valid && stage_cmd.write;
      end
   end

   // ==========================================================================
   // Storage and byte-lane merge
   logic [LANES*(LANE_W+1)-1:0] mem [DEPTH];
   logic [LANES*(LANE_W+1)-1:0] old_word;
   logic [LANES*(LANE_W+1)-1:0] merged_word;
   logic [LANES*(LANE_W+1)-1:0] read_word;
   logic commit_write;

   assign old_word = mem[stage_wr.addr];
   assign commit_write = qual && awake && stage_wr.valid;

   // Each lane holds its byte and its parity bit, steered by one select
   always_comb begin
      merged_word = old_word;
      for (int i = 0; i < LANES; i++) begin
         if (!stage_wr.lane_sel_n[i]) begin
            merged_word[i*(LANE_W+1) +: LANE_W+1] =
               {parity_lines_in[i], data_lines_in[i*LANE_W +: LANE_W]};
         end
      end
   end

   // Storage has no reset: contents survive reset and sleep alike
   always_ff @(posedge mclk) begin
      if (commit_write) mem[stage_wr.addr] <= merged_word;
   end

   // A read that hits the word being written this edge sees the new bytes
   assign read_word = (stage_wr.valid && stage_wr.addr == stage_cmd.addr) ?
      merged_word : mem[stage_cmd.addr];

   // ==========================================================================
   // Output register and drivers
   logic read_active;

   always_ff @(posedge mclk) begin
      if (!resetn || !awake) begin
         read_active <= 1'b0;
      end else if (qual) begin
         // Writes and deselects both drop the drive at this edge
         read_active <= stage_cmd.valid && !stage_cmd.write;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         data_lines_out <= '0;
         parity_lines_out <= '0;
      end else if (qual && awake && stage_cmd.valid && !stage_cmd.write) begin
         for (int i = 0; i < LANES; i++) begin
            data_lines_out[i*LANE_W +: LANE_W] <= read_word[i*(LANE_W+1) +: LANE_W];
            parity_lines_out[i] <= read_word[i*(LANE_W+1) + LANE_W];
         end
      end
   end

   // Enable is a synchronised copy of the pin, so it lags the pin by four
   // cycles; controllers must leave that margin before driving
   assign data_lines_oe = read_active && !oe_level_n && awake;
   assign parity_lines_oe = data_lines_oe;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_stall_holds: assert property (clk_qualify_n && awake |=>
      $stable(stage_cmd) && $stable(data_lines_out) && $stable(burst_step))
      else $error("state changed on an unqualified edge");
   a_read_latency: assert property (qual && awake && stage_cmd.valid && !stage_cmd.write
      ##1 awake |-> read_active)
      else $error("read data not launched one edge after acceptance");
   a_write_tristate: assert property (qual && awake && stage_cmd.valid && stage_cmd.write
      |=> !data_lines_oe && !parity_lines_oe)
      else $error("outputs driven in write data phase");
   a_deselect_pipe: assert property (qual && !stage_cmd.valid |=> !read_active)
      else $error("outputs still active after deselect");
   a_oe_gate: assert property (data_lines_oe |-> !oe_level_n && read_active)
      else $error("data driven with output enable high");
   a_write_store: assert property (commit_write |=>
      mem[$past(stage_wr.addr)] == $past(merged_word))
      else $error("write data not stored at second edge");
   a_burst_linear: assert property (qual && awake && advance_or_load && !order_level
      |=> stage_cmd.addr[1:0] == $past(stage_cmd.addr[1:0]) + 2'h1)
      else $error("linear burst address did not step by one");
   // Step n to n+1 of an XOR sequence flips bit 0 always and bit 1 after odd steps
   a_burst_interleave: assert property (qual && awake && advance_or_load && order_level
      |=> stage_cmd.addr[1:0] == ($past(stage_cmd.addr[1:0]) ^ {$past(burst_step[0]), 1'b1}))
      else $error("interleaved burst address wrong");
   a_burst_type: assert property (qual && awake && advance_or_load
      |=> stage_cmd.write == $past(stage_cmd.write) && stage_cmd.valid == $past(stage_cmd.valid))
      else $error("burst changed its access type");
   a_sleep_entry: assert property ($rose(sleep_level) && awake
      |-> ##2 power_state == ENTERING ##1 power_state == ASLEEP)
      else $error("sleep entry did not take two cycles");
   a_sleep_exit: assert property ($fell(sleep_level) && power_state == ASLEEP
      |=> power_state == LEAVING ##1 power_state == LEAVING ##1 power_state == AWAKE)
      else $error("sleep exit did not take two cycles");

   c_read: cover property (qual && stage_cmd.valid && !stage_cmd.write ##1 data_lines_oe);
   c_write: cover property (commit_write && stage_wr.lane_sel_n != LANES_OFF);
   c_burst: cover property (qual && advance_or_load && stage_cmd.valid [*3]);
   c_sleep: cover property (power_state == ASLEEP ##1 power_state == LEAVING);
endmodule // burst_sram_core

// *** tb/sram_controller_model.sv ***
// Behavioural memory controller that drives the command and write-data pins
`timescale 1ns/100ps
module sram_controller_model
   import burst_sram_pkg::*;
(
   input wire logic mclk,
   output logic clk_qualify_n,
   output logic chip_select_1_n,
   output logic chip_select_2,
   output logic chip_select_3_n,
   output logic write_enable_n,
   output logic advance_or_load,
   output logic [LANES-1:0] byte_lane_select_n,
   output logic [ADDR_W-1:0] address,
   output logic [DATA_W-1:0] data_lines_in,
   output logic [LANES-1:0] parity_lines_in
);
   // ====================
   // Write data trails its command by two edges
   logic p0_v = 1'b0;
   logic p1_v = 1'b0;
   logic [DATA_W-1:0] p0_d, p1_d;
   logic [LANES-1:0] p0_p, p1_p;

   // Idle as deselected until the bench issues commands
   initial begin
      {clk_qualify_n, chip_select_2, advance_or_load} = 3'h0;
      {chip_select_1_n, chip_select_3_n, write_enable_n} = 3'h7;
      byte_lane_select_n = LANES_OFF;
      address = '0;
      data_lines_in = '0;
      parity_lines_in = '0;
   end

   // Kinds: 0 deselect, 1 read, 2 write, 3 read beat, 4 write beat, 5 stalled edge
   task automatic drive(input int kind, input logic [ADDR_W-1:0] a,
      input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d, input logic [LANES-1:0] p);
      logic load;
      load = (kind == 1 || kind == 2);
      clk_qualify_n <= (kind == 5);
      chip_select_1_n <= !load;
      chip_select_2 <= load || kind == 5;
      chip_select_3_n <= !load;
      // Beats carry the opposite write level, which the device must ignore
      write_enable_n <= !(kind == 2 || kind == 3);
      advance_or_load <= (kind >= 3); // Deselects load, never advance
      byte_lane_select_n <= ln;
      address <= a;
      p0_v <= (kind == 2 || kind == 4);
      p0_d <= d;
      p0_p <= p;
   endtask

   // Data is held only for its sampling edge; otherwise it toggles so stale data cannot match
   always @(posedge mclk) begin
      p1_v <= p0_v;
      p1_d <= p0_d;
      p1_p <= p0_p;
      if (p1_v) begin
         data_lines_in <= p1_d;
         parity_lines_in <= p1_p;
      end else begin
         data_lines_in <= ~data_lines_in;
         parity_lines_in <= ~parity_lines_in;
      end
   end
endmodule // sram_controller_model

// *** tb/pipelined_burst_sram_access_bench.sv ***
// Self-checking bench of the burst SRAM access pipeline
`timescale 1ns/100ps
module pipelined_burst_sram_access_bench
   import burst_sram_pkg::*;
;
   // ====================
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic out_drive_enable_n = 1'b0;
   logic sleep_request = 1'b0;
   logic burst_order = 1'b0;
   logic clk_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n;
   logic write_enable_n, advance_or_load, data_lines_oe, parity_lines_oe;
   logic [LANES-1:0] byte_lane_select_n, parity_lines_in, parity_lines_out;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] data_lines_in, data_lines_out;
   int err_count = 0;
   int samples_checked = 0;
   logic [DATA_W-1:0] rdat [int];
   logic [LANES-1:0] rpar [int];
   logic [DATA_W+LANES-1:0] exp_q [$];
   logic [ADDR_W-1:0] base = '0;
   logic [BURST_W-1:0] beat = '0;
   logic no_out = 1'b0;
   logic cur_stall = 1'b0;
   logic stall_seen = 1'b0;

   always #4 mclk = ~mclk;

   burst_sram_core u_dut (.mclk, .resetn, .clk_qualify_n, .chip_select_1_n, .chip_select_2,
      .chip_select_3_n, .write_enable_n, .advance_or_load, .byte_lane_select_n, .address,
      .burst_order, .out_drive_enable_n, .sleep_request, .data_lines_in, .data_lines_out,
      .data_lines_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe);

   sram_controller_model u_ctl (.mclk, .clk_qualify_n, .chip_select_1_n, .chip_select_2,
      .chip_select_3_n, .write_enable_n, .advance_or_load, .byte_lane_select_n, .address,
      .data_lines_in, .parity_lines_in);

   // ====================
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic stop_test();
      $display("checked %0d values, %0d mismatches", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One command per edge; the reference memory follows writes at issue time
   task automatic step(input int kind, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln);
      logic [DATA_W-1:0] d;
      logic [LANES-1:0] p;
      int ea;
      d = $urandom;
      p = LANES'($urandom);
      if (kind == 1 || kind == 2) begin
         base = a;
         beat = '0;
      end else if (kind == 3 || kind == 4) begin
         beat = beat + BURST_STEP;
      end
      ea = {base[ADDR_W-1:2],
         burst_order ? base[1:0] ^ beat : base[1:0] + beat};
      if (kind == 2 || kind == 4) begin
         for (int i = 0; i < LANES; i++) begin
            if (!ln[i]) begin
               rdat[ea][LANE_W*i +: LANE_W] = d[LANE_W*i +: LANE_W];
               rpar[ea][i] = p[i];
            end
         end
      end
      if ((kind == 1 || kind == 3) && !no_out) exp_q.push_back({rpar[ea], rdat[ea]});
      @(posedge mclk);
      cur_stall <= (kind == 5);
      u_ctl.drive(kind, a, ln, d, p);
   endtask

   // A driven output after a qualified edge is a result; a stalled edge only holds it
   always @(posedge mclk) stall_seen <= cur_stall;
   always @(negedge mclk) begin
      if (resetn && !stall_seen && data_lines_oe !== 1'b0) begin
         if (exp_q.size() == 0) check(64'(data_lines_oe), 64'h0);
         else check(64'({parity_lines_oe, parity_lines_out, data_lines_out}),
            {27'h0, 1'b1, exp_q.pop_front()});
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      stop_test();
   end

   // ====================
   initial begin
      void'($urandom(32'h9E0F));
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) step(0, '0, LANES_OFF);
      for (int i = 32; i < 40; i++) begin
         step(2, ADDR_W'(i), 4'h0);
         step(1, ADDR_W'(i), 4'h0);
      end
      for (int i = 32; i < 40; i++) step(1, ADDR_W'(i), 4'h0);
      repeat (2) step(0, '0, LANES_OFF);
      $display("test 1 single writes and reads done");
      for (int m = 0; m < 16; m++) begin
         step(2, 18'h28, LANES'(m));
         step(1, 18'h28, 4'h0);
      end
      $display("test 2 byte lanes done");
      for (int o = 0; o < 2; o++) begin
         burst_order <= o[0];
         repeat (5) step(0, '0, LANES_OFF);
         for (int s = 0; s < 4; s++) begin
            step(2, ADDR_W'(32 + s), 4'h0);
            step(4, '0, 4'h0);
            step(4, '0, 4'h5);
            step(4, '0, 4'h0);
            step(1, ADDR_W'(32 + s), 4'h0);
            step(3, '0, 4'h0);
            step(5, ADDR_W'($urandom), 4'h0);
            step(3, '0, 4'h0);
            step(3, '0, 4'h0);
            step(0, '0, LANES_OFF);
         end
      end
      $display("test 3 bursts done");
      out_drive_enable_n <= 1'b1;
      no_out = 1'b1;
      repeat (5) step(0, '0, LANES_OFF);
      step(1, 18'h20, 4'h0);
      repeat (3) step(0, '0, LANES_OFF);
      out_drive_enable_n <= 1'b0;
      repeat (5) step(0, '0, LANES_OFF);
      no_out = 1'b0;
      $display("test 4 output enable done");
      sleep_request <= 1'b1;
      no_out = 1'b1;
      repeat (8) step(0, '0, LANES_OFF);
      step(1, 18'h21, 4'h0);
      repeat (2) step(0, '0, LANES_OFF);
      sleep_request <= 1'b0;
      repeat (8) step(0, '0, LANES_OFF);
      no_out = 1'b0;
      for (int i = 32; i < 40; i++) step(1, ADDR_W'(i), 4'h0);
      repeat (3) step(0, '0, LANES_OFF);
      check(64'(exp_q.size()), 64'h0);
      $display("test 5 sleep done");
      stop_test();
   end
endmodule // pipelined_burst_sram_access_bench
